// ### verification/dplc_checker.sv
// Port-level checker for the loop configuration bank.
// Assumes it is bound to dplc_bank and sees only that module's ports.
`timescale 1ns/1ps
`include "dplc_regs.svh"

module dplc_checker (
    input wire logic                 clock_i,
    input wire logic                 rst_i,
    input wire logic [7:0]           cpu_addr_i,
    input wire logic [7:0]           cpu_wdata_i,
    input wire logic                 cpu_wr_i,
    input wire logic                 cpu_rd_i,
    input wire dplc_pkg::dplc_meas_t aux_meas_i,
    input wire dplc_pkg::dplc_cfg_t  loop_cfg_o,
    input wire logic                 cpu_rvalid_o,
    input wire logic                 aux_bw_valid_o,
    input wire logic                 aux_damp_valid_o,
    input wire logic                 meas_damp_valid_o,
    input wire logic                 wide_range_on_o,
    input wire logic                 aux_phase_lost_o,
    input wire logic                 aux_loop_lock_flag_o,
    input wire logic signed [23:0]   aux_phase_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence rd_req_s;
        cpu_rd_i;
    endsequence
    sequence bw_wr_s;
        cpu_wr_i && !cpu_rd_i && cpu_addr_i == `DPLC_OFS_AUX_BW;
    endsequence

    rd_answer_a: assert property (rd_req_s |=> cpu_rvalid_o)
        else $error("read strobe got no read valid");
    rvalid_cause_a: assert property (cpu_rvalid_o |-> $past(cpu_rd_i))
        else $error("read valid without a read strobe");
    bw_write_a: assert property (bw_wr_s |=> (loop_cfg_o.aux_loop_bw_sel == $past(cpu_wdata_i[1:0]))
        ##1 (aux_bw_valid_o == ($past(cpu_wdata_i[1:0], 2) != 2'h3))) else $error("bandwidth write mishandled");
    aux_damp_a: assert property (aux_damp_valid_o ==
        ($past(loop_cfg_o.aux_loop_damping_sel) inside {[3'h1:3'h5]})) else $error("aux damping valid wrong");
    meas_damp_a: assert property (meas_damp_valid_o ==
        ($past(loop_cfg_o.measure_loop_damping_sel) inside {[3'h1:3'h5]})) else $error("measure damping valid wrong");
    wide_follow_a: assert property (wide_range_on_o == $past(loop_cfg_o.wide_range_enable))
        else $error("wide range flag wrong");
    inact_loss_a: assert property (loop_cfg_o.inactivity_loss_enable && !aux_meas_i.activity
        |=> aux_phase_lost_o && !aux_loop_lock_flag_o) else $error("inactivity did not raise loss");
    fine_loss_a: assert property (loop_cfg_o.fine_enable &&
        aux_meas_i.phase_deg > 24'sd45 * $signed({1'b0, loop_cfg_o.fine_window_code})
        |=> aux_phase_lost_o) else $error("fine window loss missing");
    phase_clamp_a: assert property (!(loop_cfg_o.multi_cycle_phase_use && loop_cfg_o.wide_range_enable)
        |=> aux_phase_o <= 24'sd360 && aux_phase_o >= -24'sd360) else $error("phase not clamped");
endmodule // dplc_checker

bind dplc_bank dplc_checker i_chk (.clock_i(clock_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .aux_meas_i(aux_meas_i),
    .loop_cfg_o(loop_cfg_o), .cpu_rvalid_o(cpu_rvalid_o), .aux_bw_valid_o(aux_bw_valid_o),
    .aux_damp_valid_o(aux_damp_valid_o), .meas_damp_valid_o(meas_damp_valid_o),
    .wide_range_on_o(wide_range_on_o), .aux_phase_lost_o(aux_phase_lost_o),
    .aux_loop_lock_flag_o(aux_loop_lock_flag_o), .aux_phase_o(aux_phase_o));

// ### verification/test_dplc_bank.sv
// Self-checking bench for the loop configuration bank.
// Assumes the checker is bound in; both loops get the same measurement input.
`timescale 1ns/1ps

module test_dplc_bank;
    logic                 clock_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [7:0]           addr = 8'h00;
    logic [7:0]           wdata = 8'h00;
    logic                 wr = 1'b0;
    logic                 rd = 1'b0;
    dplc_pkg::dplc_meas_t meas = '{1'b1, 14'sd0, 24'sd0};
    dplc_pkg::dplc_cfg_t  cfg;
    logic [7:0]           rdata;
    logic                 rvalid, bw_ok, adamp_ok, mdamp_ok, wide, alost, mlost, lock;
    logic signed [23:0]   aph, mph;
    int                   errors = 0;
    int                   n_compared = 0;
    int                   cycles = 0;
    // Address, write data and masked readback; the last row is unmapped.
    logic [23:0] rows [8] = '{24'h66ff03, 24'h660202, 24'h67ee0e, 24'h6a9d15,
                              24'h6b1515, 24'h73ffe7, 24'h74ffef, 24'h50ff00};
    logic [15:0] rst_rows [6] = '{16'h6600, 16'h670b, 16'h6a13, 16'h6b13, 16'h73a2, 16'h7485};

    always #5 clock_i = ~clock_i;

    dplc_bank i_dut (.clock_i(clock_i), .rst_i(rst_i), .cpu_addr_i(addr), .cpu_wdata_i(wdata),
        .cpu_wr_i(wr), .cpu_rd_i(rd), .aux_meas_i(meas), .meas_meas_i(meas), .loop_cfg_o(cfg),
        .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid), .aux_bw_valid_o(bw_ok), .aux_damp_valid_o(adamp_ok),
        .meas_damp_valid_o(mdamp_ok), .wide_range_on_o(wide), .aux_phase_lost_o(alost),
        .meas_phase_lost_o(mlost), .aux_loop_lock_flag_o(lock), .aux_phase_o(aph), .meas_phase_o(mph));

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_sig(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clock_i);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        rd = 1'b1;
        addr = a;
        @(negedge clock_i);
        rd = 1'b0;
        chk_sig({23'h0, rvalid}, 24'h000001);
        chk_reg(rdata, exp);
    endtask

    // Loss and phase are registered, so they are judged one cycle after the input.
    task automatic meas_chk(input logic act, input logic signed [13:0] cnt, input logic signed [23:0] ph,
                            input logic exp_lost, input logic signed [23:0] exp_ph);
        @(negedge clock_i);
        meas = '{act, cnt, ph};
        @(negedge clock_i);
        chk_sig({23'h0, alost}, {23'h0, exp_lost});
        chk_sig({23'h0, mlost}, {23'h0, exp_lost});
        chk_sig({23'h0, lock}, {23'h0, ~exp_lost});
        chk_sig(aph, exp_ph);
        chk_sig(mph, exp_ph);
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        foreach (rst_rows[i]) rd_chk(rst_rows[i][15:8], rst_rows[i][7:0]);
        $display("reset values done");
        foreach (rows[i]) begin
            wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_chk(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(8'h66, 8'(c));
            repeat (2) @(negedge clock_i);
            chk_sig({23'h0, bw_ok}, {23'h0, c != 3});
        end
        @(negedge clock_i);
        rst_i = 1'b1;
        @(negedge clock_i);
        rst_i = 1'b0;
        rd_chk(8'h66, 8'h00);
        chk_sig({23'h0, bw_ok}, 24'h000001);
        chk_sig({23'h0, wide}, 24'h000000);
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'h6a, {5'h2, 3'(c)});
            wr_reg(8'h6b, {5'h2, 3'(c)});
            repeat (2) @(negedge clock_i);
            chk_sig({23'h0, adamp_ok}, {23'h0, c >= 1 && c <= 5});
            chk_sig({23'h0, mdamp_ok}, {23'h0, c >= 1 && c <= 5});
        end
        $display("selector codes done");
        wr_reg(8'h74, 8'h00);
        wr_reg(8'h73, 8'h62);
        meas_chk(1'b0, 14'sd0, 24'sd0, 1'b1, 24'sd0);
        meas_chk(1'b1, 14'sd0, 24'sd0, 1'b0, 24'sd0);
        wr_reg(8'h73, 8'ha2);
        meas_chk(1'b1, 14'sd0, 24'sd91, 1'b1, 24'sd91);
        meas_chk(1'b1, 14'sd0, 24'sd90, 1'b0, 24'sd90);
        meas_chk(1'b1, 14'sd0, -24'sd91, 1'b1, -24'sd91);
        meas_chk(1'b0, 14'sd0, 24'sd0, 1'b0, 24'sd0);
        $display("fine and inactivity done");
        wr_reg(8'h73, 8'h22);
        wr_reg(8'h74, 8'h82);
        meas_chk(1'b1, 14'sd8, 24'sd0, 1'b1, 24'sd0);
        meas_chk(1'b1, 14'sd7, 24'sd0, 1'b0, 24'sd0);
        meas_chk(1'b1, -14'sd8, 24'sd0, 1'b1, 24'sd0);
        wr_reg(8'h74, 8'h02);
        meas_chk(1'b1, 14'sd8, 24'sd0, 1'b0, 24'sd0);
        meas_chk(1'b1, 14'sd0, 24'sd1000, 1'b0, 24'sd360);
        meas_chk(1'b1, 14'sd0, -24'sd1000, 1'b0, -24'sd360);
        wr_reg(8'h74, 8'h40);
        meas_chk(1'b1, 14'sd0, 24'sd1000, 1'b0, 24'sd360);
        chk_sig({23'h0, wide}, 24'h000001);
        wr_reg(8'h74, 8'h60);
        meas_chk(1'b1, 14'sd0, 24'sd1000, 1'b0, 24'sd1000);
        chk_sig({23'h0, wide}, 24'h000001);
        $display("coarse and phase done");
        give_verdict();
    end
endmodule // test_dplc_bank

// ### verilog/dplc_bank.sv
// Configuration bank for the auxiliary timing-path loop and the measurement loop.
// Assumes a synchronous parallel register port and measurements synchronous to clock_i.
`timescale 1ns/1ps
`include "dplc_regs.svh"

// Functional notes
// - Auxiliary bandwidth code selects 18, 35, 70 Hz.
// - Measurement bandwidth uses five-bit code.
// - Auxiliary damping codes 001-101, default 011.
// - Measurement damping codes 001-101, default 011.
// - Fine enable flags loss beyond window.
// - Inactivity bit raises phase loss on the next clock.
// - Bit six enables wide-range phase detector.
// - Multi-cycle bit with wide range passes full coarse phase.
// - Otherwise loop phase limited to one cycle.
module dplc_bank (
    input  wire logic                          clock_i,
    input  wire logic                          rst_i,
    input  wire logic [`DPLC_ADDR_W-1:0]       cpu_addr_i,
    input  wire logic [`DPLC_DATA_W-1:0]       cpu_wdata_i,
    input  wire logic                          cpu_wr_i,
    input  wire logic                          cpu_rd_i,
    input  wire dplc_pkg::dplc_meas_t          aux_meas_i,
    input  wire dplc_pkg::dplc_meas_t          meas_meas_i,
    output dplc_pkg::dplc_cfg_t                loop_cfg_o,
    output logic [`DPLC_DATA_W-1:0]            cpu_rdata_o,
    output logic                               cpu_rvalid_o,
    output logic                               aux_bw_valid_o,
    output logic                               aux_damp_valid_o,
    output logic                               meas_damp_valid_o,
    output logic                               wide_range_on_o,
    output logic                               aux_phase_lost_o,
    output logic                               meas_phase_lost_o,
    output logic                               aux_loop_lock_flag_o,
    output logic signed [23:0]                 aux_phase_o,
    output logic signed [23:0]                 meas_phase_o
);

    typedef struct packed {
        dplc_pkg::dplc_cfg_t             cfg;
        logic [`DPLC_DATA_W-1:0]         rdata;
        logic                            rvalid;
        logic                            aux_bw_valid;
        logic                            aux_damp_valid;
        logic                            meas_damp_valid;
        logic                            wide_on;
        logic [`DPLC_NUM_LOOPS-1:0]      lost;
        logic                            aux_lock;
        logic signed [23:0]              aux_phase;
        logic signed [23:0]              meas_phase;
    } dplc_state_t;

    // Applies a write to the register copy; only defined bits are kept.
    function automatic dplc_pkg::dplc_cfg_t cfg_write(input dplc_pkg::dplc_cfg_t c,
                                                      input logic [7:0] a,
                                                      input logic [7:0] d);
        dplc_pkg::dplc_cfg_t r;
        r = c;
        unique case (a)
            `DPLC_OFS_AUX_BW: begin
                r.aux_loop_bw_sel = dplc_pkg::dplc_aux_bw_t'(d[1:0]);
            end
            `DPLC_OFS_MEAS_BW: begin
                r.measure_loop_bw_sel = d[4:0];
            end
            `DPLC_OFS_AUX_DAMP: begin
                r.aux_damp_fixed       = d[`DPLC_DAMP_FIX_LSB+:3];
                r.aux_loop_damping_sel = d[2:0];
            end
            `DPLC_OFS_MEAS_DAMP: begin
                r.meas_damp_fixed          = d[`DPLC_DAMP_FIX_LSB+:3];
                r.measure_loop_damping_sel = d[2:0];
            end
            `DPLC_OFS_FINE: begin
                r.fine_enable            = d[`DPLC_FINE_EN_BIT];
                r.inactivity_loss_enable = d[`DPLC_INACT_BIT];
                r.narrow_test            = d[`DPLC_NARROW_BIT];
                r.fine_window_code       = d[2:0];
            end
            `DPLC_OFS_COARSE: begin
                r.coarse_enable         = d[`DPLC_COARSE_EN_BIT];
                r.wide_range_enable     = d[`DPLC_WIDE_BIT];
                r.multi_cycle_phase_use = d[`DPLC_MULTI_BIT];
                r.coarse_limit_code     = d[3:0];
            end
            default: begin
                r = c;
            end
        endcase
        return r;
    endfunction

    // Reads back the register copy; unused bits and unmapped offsets read zero.
    function automatic logic [7:0] cfg_read(input dplc_pkg::dplc_cfg_t c, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `DPLC_OFS_AUX_BW: begin
                v = {6'h00, c.aux_loop_bw_sel};
            end
            `DPLC_OFS_MEAS_BW: begin
                v = {3'h0, c.measure_loop_bw_sel};
            end
            `DPLC_OFS_AUX_DAMP: begin
                v = {1'b0, c.aux_damp_fixed, 1'b0, c.aux_loop_damping_sel};
            end
            `DPLC_OFS_MEAS_DAMP: begin
                v = {1'b0, c.meas_damp_fixed, 1'b0, c.measure_loop_damping_sel};
            end
            `DPLC_OFS_FINE: begin
                v = {c.fine_enable, c.inactivity_loss_enable, c.narrow_test, 2'h0, c.fine_window_code};
            end
            `DPLC_OFS_COARSE: begin
                v = {c.coarse_enable, c.wide_range_enable, c.multi_cycle_phase_use, 1'b0, c.coarse_limit_code};
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    function automatic logic damp_ok(input logic [2:0] code);
        damp_ok = (code >= `DPLC_DAMP_MIN) && (code <= `DPLC_DAMP_MAX);
    endfunction

    function automatic dplc_pkg::dplc_cfg_t cfg_reset();
        dplc_pkg::dplc_cfg_t r;
        r = '0;
        r = cfg_write(r, `DPLC_OFS_AUX_BW,    `DPLC_RST_AUX_BW);
        r = cfg_write(r, `DPLC_OFS_MEAS_BW,   `DPLC_RST_MEAS_BW);
        r = cfg_write(r, `DPLC_OFS_AUX_DAMP,  `DPLC_RST_AUX_DAMP);
        r = cfg_write(r, `DPLC_OFS_MEAS_DAMP, `DPLC_RST_MEAS_DAMP);
        r = cfg_write(r, `DPLC_OFS_FINE,      `DPLC_RST_FINE);
        r = cfg_write(r, `DPLC_OFS_COARSE,    `DPLC_RST_COARSE);
        return r;
    endfunction

    localparam dplc_pkg::dplc_cfg_t CFG_RST = cfg_reset();

    dplc_state_t          state_ff;
    dplc_state_t          nxt_state;
    dplc_pkg::dplc_meas_t meas_arr [`DPLC_NUM_LOOPS];
    dplc_pkg::dplc_res_t  res_arr  [`DPLC_NUM_LOOPS];

    assign meas_arr[`DPLC_LOOP_AUX]  = aux_meas_i;
    assign meas_arr[`DPLC_LOOP_MEAS] = meas_meas_i;

    // Both loops share one phase-loss configuration, so one evaluator per loop suffices.
    for (genvar g = 0; g < `DPLC_NUM_LOOPS; g++) begin : g_loop
        dplc_loss u_loss (
            .cfg_i  (state_ff.cfg),
            .meas_i (meas_arr[g]),
            .res_o  (res_arr[g])
        );
    end

    always_comb begin
        nxt_state        = state_ff;
        nxt_state.rvalid = cpu_rd_i;
        if (cpu_rd_i) begin
            nxt_state.rdata = cfg_read(state_ff.cfg, cpu_addr_i);
        end
        if (cpu_wr_i) begin
            nxt_state.cfg = cfg_write(state_ff.cfg, cpu_addr_i, cpu_wdata_i);
        end
        // Unused codes are reported, not corrected, since software owns the legal choice.
        nxt_state.aux_bw_valid    = (state_ff.cfg.aux_loop_bw_sel != dplc_pkg::DPLC_BW_UNUSED);
        nxt_state.aux_damp_valid  = damp_ok(state_ff.cfg.aux_loop_damping_sel);
        nxt_state.meas_damp_valid = damp_ok(state_ff.cfg.measure_loop_damping_sel);
        nxt_state.wide_on         = state_ff.cfg.wide_range_enable;
        for (int i = 0; i < `DPLC_NUM_LOOPS; i++) begin
            nxt_state.lost[i] = res_arr[i].lost;
        end
        // The lock flag is its own flip-flop so that the output carries no inverter after the register.
        nxt_state.aux_lock   = !res_arr[`DPLC_LOOP_AUX].lost;
        nxt_state.aux_phase  = res_arr[`DPLC_LOOP_AUX].phase_deg;
        nxt_state.meas_phase = res_arr[`DPLC_LOOP_MEAS].phase_deg;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff                 <= '0;
            state_ff.cfg             <= CFG_RST;
            state_ff.aux_bw_valid    <= 1'b1;
            state_ff.aux_damp_valid  <= 1'b1;
            state_ff.meas_damp_valid <= 1'b1;
            state_ff.wide_on         <= 1'b0;
            state_ff.aux_lock        <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign loop_cfg_o           = state_ff.cfg;
    assign cpu_rdata_o          = state_ff.rdata;
    assign cpu_rvalid_o         = state_ff.rvalid;
    assign aux_bw_valid_o       = state_ff.aux_bw_valid;
    assign aux_damp_valid_o     = state_ff.aux_damp_valid;
    assign meas_damp_valid_o    = state_ff.meas_damp_valid;
    assign wide_range_on_o      = state_ff.wide_on;
    assign aux_phase_lost_o     = state_ff.lost[`DPLC_LOOP_AUX];
    assign meas_phase_lost_o    = state_ff.lost[`DPLC_LOOP_MEAS];
    assign aux_loop_lock_flag_o = state_ff.aux_lock;
    assign aux_phase_o          = state_ff.aux_phase;
    assign meas_phase_o         = state_ff.meas_phase;

endmodule // dplc_bank

// ### verilog/dplc_loss.sv
// Phase-loss evaluator for one loop: fine window, inactivity and coarse cycle limit.
// Assumes measurements are synchronous to the caller's clock; purely combinational.
`timescale 1ns/1ps
`include "dplc_regs.svh"

module dplc_loss (
    input  wire dplc_pkg::dplc_cfg_t  cfg_i,
    input  wire dplc_pkg::dplc_meas_t meas_i,
    output dplc_pkg::dplc_res_t       res_o
);

    function automatic logic [23:0] abs24(input logic signed [23:0] v);
        abs24 = v[23] ? 24'(-v) : 24'(v);
    endfunction

    logic [23:0] fine_window;
    logic [13:0] cycle_mag;
    logic [13:0] coarse_limit;
    logic [3:0]  code_cl;
    logic        fine_loss;
    logic        inact_loss;
    logic        coarse_loss;

    always_comb begin
        // The window grows with its code, so code zero gives a zero window and loss at any nonzero phase.
        fine_window  = 24'(cfg_i.fine_window_code) * `DPLC_FINE_STEP_DEG;
        fine_loss    = cfg_i.fine_enable && (abs24(meas_i.phase_deg) > fine_window);
        inact_loss   = cfg_i.inactivity_loss_enable && !meas_i.activity;
        cycle_mag    = meas_i.cycle_count[13] ? 14'(-meas_i.cycle_count) : 14'(meas_i.cycle_count);
        code_cl      = (cfg_i.coarse_limit_code > `DPLC_COARSE_TOP_CODE) ? `DPLC_COARSE_TOP_CODE
                                                                         : cfg_i.coarse_limit_code;
        coarse_limit = 14'((15'h0002 << code_cl) - 15'h0001);
        coarse_loss  = cfg_i.coarse_enable && (cycle_mag > coarse_limit);
        res_o.lost   = fine_loss || inact_loss || coarse_loss;
        // Without the multi-cycle result the loop sees at most one cycle of phase either way.
        if (cfg_i.multi_cycle_phase_use && cfg_i.wide_range_enable) begin
            res_o.phase_deg = meas_i.phase_deg;
        end else if (!meas_i.phase_deg[23] && (meas_i.phase_deg > $signed(`DPLC_ONE_UI_DEG))) begin
            res_o.phase_deg = $signed(`DPLC_ONE_UI_DEG);
        end else if (meas_i.phase_deg[23] && (meas_i.phase_deg < -$signed(`DPLC_ONE_UI_DEG))) begin
            res_o.phase_deg = 24'(-$signed(`DPLC_ONE_UI_DEG));
        end else begin
            res_o.phase_deg = meas_i.phase_deg;
        end
    end

endmodule // dplc_loss

// ### verilog/dplc_pkg.sv
// Types shared by the loop configuration bank and its phase-loss evaluator.
// Assumes the register header is on the include path.
`include "dplc_regs.svh"

package dplc_pkg;

    typedef enum logic [1:0] {
        DPLC_BW_18HZ   = 2'b00,
        DPLC_BW_35HZ   = 2'b01,
        DPLC_BW_70HZ   = 2'b10,
        DPLC_BW_UNUSED = 2'b11
    } dplc_aux_bw_t;

    typedef struct packed {
        dplc_aux_bw_t aux_loop_bw_sel;
        logic [4:0]   measure_loop_bw_sel;
        logic [2:0]   aux_damp_fixed;
        logic [2:0]   aux_loop_damping_sel;
        logic [2:0]   meas_damp_fixed;
        logic [2:0]   measure_loop_damping_sel;
        logic         fine_enable;
        logic         inactivity_loss_enable;
        logic         narrow_test;
        logic [2:0]   fine_window_code;
        logic         coarse_enable;
        logic         wide_range_enable;
        logic         multi_cycle_phase_use;
        logic [3:0]   coarse_limit_code;
    } dplc_cfg_t;

    typedef struct packed {
        logic                activity;
        logic signed [13:0]  cycle_count;
        logic signed [23:0]  phase_deg;
    } dplc_meas_t;

    typedef struct packed {
        logic                lost;
        logic signed [23:0]  phase_deg;
    } dplc_res_t;

endpackage

// ### verilog/dplc_regs.svh
// Register offsets, reset values, masks and field positions of the loop configuration bank.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef DPLC_REGS_SVH
`define DPLC_REGS_SVH

`define DPLC_ADDR_W            8
`define DPLC_DATA_W            8

`define DPLC_OFS_AUX_BW        8'h66
`define DPLC_OFS_MEAS_BW       8'h67
`define DPLC_OFS_AUX_DAMP      8'h6a
`define DPLC_OFS_MEAS_DAMP     8'h6b
`define DPLC_OFS_FINE          8'h73
`define DPLC_OFS_COARSE        8'h74

`define DPLC_RST_AUX_BW        8'h00
`define DPLC_RST_MEAS_BW       8'h0b
`define DPLC_RST_AUX_DAMP      8'h13
`define DPLC_RST_MEAS_DAMP     8'h13
`define DPLC_RST_FINE          8'ha2
`define DPLC_RST_COARSE        8'h85

`define DPLC_MSK_AUX_BW        8'h03
`define DPLC_MSK_MEAS_BW       8'h1f
`define DPLC_MSK_DAMP          8'h77
`define DPLC_MSK_FINE          8'he7
`define DPLC_MSK_COARSE        8'hef

`define DPLC_DAMP_FIX_LSB      4
`define DPLC_FINE_EN_BIT       7
`define DPLC_INACT_BIT         6
`define DPLC_NARROW_BIT        5
`define DPLC_COARSE_EN_BIT     7
`define DPLC_WIDE_BIT          6
`define DPLC_MULTI_BIT         5

`define DPLC_AUX_BW_UNUSED     2'h3
`define DPLC_DAMP_MIN          3'h1
`define DPLC_DAMP_MAX          3'h5
`define DPLC_FINE_STEP_DEG     24'h00002d
`define DPLC_ONE_UI_DEG        24'h000168
`define DPLC_COARSE_TOP_CODE   4'hc
`define DPLC_NUM_LOOPS         2
`define DPLC_LOOP_AUX          0
`define DPLC_LOOP_MEAS         1

`endif
